// ---- src/bflg_pkg.sv ----
// Constants, types and register map of the boot lock flash guard.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit byte pointer into program flash.
package bflg_pkg;

	localparam int PTR_W = 16;
	localparam int WORD_W = 15;
	localparam int WIP_W = 5;
	localparam int PAGE_W = 10;

	// Register byte offsets.
	localparam logic [7:0] OFS_POINTER = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_GUARD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// Field positions.
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_GUARD_LSB = 2;
	localparam int GUARD_FUSE_BIT = 0;
	localparam int GUARD_VEC_BIT = 1;
	localparam int GUARD_FIELD_LSB = 2;
	localparam int STAT_DONE_BIT = 16;
	localparam int STAT_SREF_BIT = 17;
	localparam int STAT_LREF_BIT = 18;
	localparam int STAT_IRQ_BIT = 19;

	// Bit order inside the four-bit guard field.
	localparam int GB_APP_WRITE = 0;
	localparam int GB_APP_READ = 1;
	localparam int GB_BOOT_WRITE = 2;
	localparam int GB_BOOT_READ = 3;

	// Reset values.
	localparam logic [3:0] GUARD_ERASED = 4'hF;
	localparam logic [15:0] POINTER_RST = 16'h0000;
	localparam logic [5:0] CONTROL_RST = 6'h3C;
	localparam logic [14:0] APP_RESET_ADDR = 15'h0000;
	localparam logic [14:0] BOOT_START_DEF = 15'h0C00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		OP_FILL = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10,
		OP_GUARD = 2'b11
	} bflg_op_type;

	typedef enum logic [0:0] {
		BUS_ADDR = 1'b0,
		BUS_WDATA = 1'b1
	} bflg_bus_type;

	typedef struct packed {
		logic valid;
		bflg_op_type op;
		logic [PAGE_W-1:0] page;
		logic [WIP_W-1:0] word;
		logic [3:0] guard;
	} bflg_flash_cmd_type;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] word;
		logic highByte;
	} bflg_flash_read_type;

endpackage

// ---- src/bflg_sync.sv ----
// Two-stage synchroniser for pin levels entering the mclk domain.
// Assumes each bit is a slowly changing level; bits are not coherent with each other.
`timescale 1ns/1ps
module bflg_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async,
	output logic [W-1:0] synced
);

	logic [W-1:0] stage1_reg;

	// First stage feeds only the second stage.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stage1_reg <= RST;
			synced <= RST;
		end else begin
			stage1_reg <= async;
			synced <= stage1_reg;
		end
	end

endmodule

// ---- src/bflg_guard.sv ----
// Boot lock flash guard: checks store and load requests from the core against the guard bits.
// Assumes the core gives its executing word address and one-cycle request pulses on mclk;
// programmer pins are asynchronous levels; registers sit behind an AHB-Lite slave.
`timescale 1ns/1ps
module bflg_guard #(
	parameter logic [14:0] BOOT_START_WORD = bflg_pkg::BOOT_START_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [14:0] coreExecAddr,
	input wire logic coreStoreReq,
	input wire logic coreLoadReq,
	input wire logic coreVecInBoot,
	input wire logic fuseBootResetPin,
	input wire logic progChipErasePin,
	input wire logic progGuardStrobePin,
	input wire logic [3:0] progGuardDataPin,
	output bflg_pkg::bflg_flash_cmd_type flashCmd,
	output bflg_pkg::bflg_flash_read_type flashRead,
	output logic storeRefused,
	output logic loadRefused,
	output logic irqInhibit,
	output logic [14:0] resetVector
);

	// Elaboration checks: boot start must leave room for at least one application page and
	// sit on a page boundary, and the package widths must split the pointer exactly.
	if (BOOT_START_WORD == 15'h0000) begin
		$error("BOOT_START_WORD must be nonzero");
	end
	if (BOOT_START_WORD[bflg_pkg::WIP_W-1:0] != '0) begin
		$error("BOOT_START_WORD must be page aligned");
	end
	if (bflg_pkg::PAGE_W + bflg_pkg::WIP_W != bflg_pkg::WORD_W) begin
		$error("page and word fields must cover the word address");
	end
	if (bflg_pkg::WORD_W + 1 != bflg_pkg::PTR_W) begin
		$error("word address must be the byte pointer without its low bit");
	end

	logic [6:0] pinSync;
	logic fuseBootRst;
	logic chipErase;
	logic extProg;
	logic [3:0] extData;
	logic chipErasePrev_reg;
	logic extProgPrev_reg;
	logic chipEraseEdge;
	logic extProgEdge;

	bflg_sync #(
		.W(7),
		.RST(7'h7F)
	) u_pinSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async({fuseBootResetPin, progChipErasePin, progGuardStrobePin, progGuardDataPin}),
		.synced(pinSync)
	);

	// Split the synchronised pin group into its levels.
	assign fuseBootRst = pinSync[6];
	assign chipErase = pinSync[5];
	assign extProg = pinSync[4];
	assign extData = pinSync[3:0];

	// Edge detection looks only at the synchronised stage.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chipErasePrev_reg <= 1'b1;
			extProgPrev_reg <= 1'b1;
		end else begin
			chipErasePrev_reg <= chipErase;
			extProgPrev_reg <= extProg;
		end
	end

	// A rising level after synchronisation starts one chip erase or one guard programming.
	assign chipEraseEdge = chipErase && !chipErasePrev_reg;
	assign extProgEdge = extProg && !extProgPrev_reg;

	// Bus state and registers.
	bflg_pkg::bflg_bus_type bus_reg;
	bflg_pkg::bflg_bus_type bus_next;
	logic [7:0] wrAddr_reg;
	logic [15:0] pointer_reg;
	logic [5:0] control_reg;
	logic [3:0] guard_reg;
	logic [3:0] guard_next;
	logic [14:0] latched_reg;
	logic storeDone_reg;
	logic [31:0] readValue;
	logic accept;

	// A transfer is taken when selected, NONSEQ, whole word and the bus is ready.
	assign accept = hsel && hready && htrans == bflg_pkg::HTRANS_NONSEQ
		&& hsize == bflg_pkg::HSIZE_WORD;

	// A write holds the data phase for one wait cycle so a following read sees the new value.
	always_comb begin
		bus_next = bus_reg;
		case (bus_reg)
			bflg_pkg::BUS_ADDR: begin
				if (accept && hwrite) begin
					bus_next = bflg_pkg::BUS_WDATA;
				end
			end
			bflg_pkg::BUS_WDATA: begin
				bus_next = bflg_pkg::BUS_ADDR;
			end
			default: begin
				bus_next = bflg_pkg::BUS_ADDR;
			end
		endcase
	end

	// Bus state register.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus_reg <= bflg_pkg::BUS_ADDR;
		end else begin
			bus_reg <= bus_next;
		end
	end

	// Write address is captured in the address phase and used in the data phase.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrAddr_reg <= 8'h00;
		end else if (accept && hwrite) begin
			wrAddr_reg <= haddr[7:0];
		end
	end

	// Ready drops for the one write wait cycle; the response is always OKAY.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= (bus_next != bflg_pkg::BUS_WDATA);
			hresp <= 1'b0;
		end
	end

	// Software-written pointer; the CPU has no fuse path here.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pointer_reg <= bflg_pkg::POINTER_RST;
		end else if (bus_reg == bflg_pkg::BUS_WDATA && wrAddr_reg == bflg_pkg::OFS_POINTER) begin
			pointer_reg <= hwdata[15:0];
		end
	end

	// Control register: operation code and the guard value a guard-set store applies.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			control_reg <= bflg_pkg::CONTROL_RST;
		end else if (bus_reg == bflg_pkg::BUS_WDATA && wrAddr_reg == bflg_pkg::OFS_CONTROL) begin
			control_reg <= hwdata[5:0];
		end
	end

	// Read data is registered in the address phase and stands in the data phase.
	always_comb begin
		readValue = 32'h00000000;
		case (haddr[7:0])
			bflg_pkg::OFS_POINTER: begin
				readValue[15:0] = pointer_reg;
			end
			bflg_pkg::OFS_CONTROL: begin
				readValue[5:0] = control_reg;
			end
			bflg_pkg::OFS_GUARD: begin
				readValue[bflg_pkg::GUARD_FIELD_LSB +: 4] = guard_reg;
				readValue[bflg_pkg::GUARD_FUSE_BIT] = fuseBootRst;
				readValue[bflg_pkg::GUARD_VEC_BIT] = coreVecInBoot;
			end
			bflg_pkg::OFS_STATUS: begin
				readValue[14:0] = latched_reg;
				readValue[bflg_pkg::STAT_DONE_BIT] = storeDone_reg;
				readValue[bflg_pkg::STAT_SREF_BIT] = storeRefused;
				readValue[bflg_pkg::STAT_LREF_BIT] = loadRefused;
				readValue[bflg_pkg::STAT_IRQ_BIT] = irqInhibit;
			end
			default: begin
				readValue = 32'h00000000;
			end
		endcase
	end

	// Read data is captured when a read address phase is taken and stands until the next one.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (accept && !hwrite) begin
			hrdata <= readValue;
		end
	end

	// Section decode of the executing code and of the pointed target.
	logic [14:0] targetWord;
	logic execBoot;
	logic targetBoot;
	bflg_pkg::bflg_op_type ctrlOp;
	logic [3:0] ctrlGuard;
	logic targetWritable;
	logic storeOk;
	logic loadOk;

	assign targetWord = pointer_reg[15:1];
	assign execBoot = coreExecAddr >= BOOT_START_WORD;
	assign targetBoot = targetWord >= BOOT_START_WORD;
	assign ctrlOp = bflg_pkg::bflg_op_type'(control_reg[bflg_pkg::CTRL_OP_LSB +: 2]);
	assign ctrlGuard = control_reg[bflg_pkg::CTRL_GUARD_LSB +: 4];

	// A zero guard bit is active; the general lock modes are never consulted here.
	assign targetWritable = targetBoot ? guard_reg[bflg_pkg::GB_BOOT_WRITE]
		: guard_reg[bflg_pkg::GB_APP_WRITE];

	// Stores start only from boot code; the guard operation does not look at the pointer.
	assign storeOk = execBoot
		&& (ctrlOp == bflg_pkg::OP_GUARD || targetWritable);

	// Cross-section loads are refused while the target section's read guard is active.
	always_comb begin
		loadOk = 1'b1;
		if (targetBoot && !execBoot && !guard_reg[bflg_pkg::GB_BOOT_READ]) begin
			loadOk = 1'b0;
		end
		if (!targetBoot && execBoot && !guard_reg[bflg_pkg::GB_APP_READ]) begin
			loadOk = 1'b0;
		end
	end

	// Guard bits only move towards active, except that chip erase restores them all.
	always_comb begin
		guard_next = guard_reg;
		if (coreStoreReq && storeOk && ctrlOp == bflg_pkg::OP_GUARD) begin
			guard_next = guard_next & ctrlGuard;
		end
		if (extProgEdge) begin
			guard_next = guard_next & extData;
		end
		if (chipEraseEdge) begin
			guard_next = bflg_pkg::GUARD_ERASED;
		end
	end

	// Guard bits reset to erased because no non-volatile copy is kept here.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			guard_reg <= bflg_pkg::GUARD_ERASED;
		end else begin
			guard_reg <= guard_next;
		end
	end

	// Accepted stores other than the guard operation latch page and word so later pointer writes cannot disturb them.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flashCmd <= '0;
		end else begin
			flashCmd.valid <= coreStoreReq && storeOk;
			if (coreStoreReq && storeOk) begin
				flashCmd.op <= ctrlOp;
				flashCmd.guard <= guard_next;
				if (ctrlOp != bflg_pkg::OP_GUARD) begin
					flashCmd.page <= targetWord[14:bflg_pkg::WIP_W];
					flashCmd.word <= targetWord[bflg_pkg::WIP_W-1:0];
				end
			end
		end
	end

	// The status copy of the started address is taken at the same moment.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			latched_reg <= 15'h0000;
		end else if (coreStoreReq && storeOk && ctrlOp != bflg_pkg::OP_GUARD) begin
			latched_reg <= targetWord;
		end
	end

	// Outcome flags of the latest store stand until the next store request.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			storeDone_reg <= 1'b0;
			storeRefused <= 1'b0;
		end else if (coreStoreReq) begin
			storeDone_reg <= storeOk;
			storeRefused <= !storeOk;
		end
	end

	// Loads go out byte-addressed; pointer bit zero selects the byte of the word.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flashRead <= '0;
		end else begin
			flashRead.valid <= coreLoadReq && loadOk;
			if (coreLoadReq) begin
				flashRead.word <= targetWord;
				flashRead.highByte <= pointer_reg[0];
			end
		end
	end

	// The load outcome stands until the next load request.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			loadRefused <= 1'b0;
		end else if (coreLoadReq) begin
			loadRefused <= !loadOk;
		end
	end

	// Interrupts are held off while code runs in the section the vectors cannot reach.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irqInhibit <= 1'b0;
		end else begin
			irqInhibit <= (!guard_reg[bflg_pkg::GB_APP_READ] && coreVecInBoot && !execBoot)
				|| (!guard_reg[bflg_pkg::GB_BOOT_READ] && !coreVecInBoot && execBoot);
		end
	end

	// Reset vector follows the programmer-owned fuse only.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			resetVector <= bflg_pkg::APP_RESET_ADDR;
		end else begin
			resetVector <= fuseBootRst ? bflg_pkg::APP_RESET_ADDR : BOOT_START_WORD;
		end
	end

endmodule

// ---- testbench/bflg_checker.sv ----
// Concurrent checks on the ports of the flash guard top module.
// Assumes it is bound into bflg_guard and sees only that module's ports.
`timescale 1ns/1ps
module bflg_checker #(
	parameter logic [14:0] BOOT_START_WORD = bflg_pkg::BOOT_START_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [14:0] coreExecAddr,
	input wire logic coreStoreReq,
	input wire logic coreLoadReq,
	input wire logic coreVecInBoot,
	input wire logic fuseBootResetPin,
	input bflg_pkg::bflg_flash_cmd_type flashCmd,
	input bflg_pkg::bflg_flash_read_type flashRead,
	input wire logic storeRefused,
	input wire logic loadRefused,
	input wire logic irqInhibit,
	input wire logic [14:0] resetVector
);
	logic [2:0] upCnt;
	logic inBoot;
	logic takeReq;
	// Counts edges since reset release so the fuse path has settled.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			upCnt <= 3'h0;
		end else if (upCnt != 3'h7) begin
			upCnt <= upCnt + 3'h1;
		end
	end
	// Executing section and a bus request that the slave takes.
	assign inBoot = coreExecAddr >= BOOT_START_WORD;
	assign takeReq = hsel && hready && htrans == bflg_pkg::HTRANS_NONSEQ
		&& hsize == bflg_pkg::HSIZE_WORD;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	app_store_refuse_a: assert property (coreStoreReq && !inBoot |=> storeRefused)
		else $error("store from application code not refused");
	store_answer_a: assert property (coreStoreReq |=> flashCmd.valid != storeRefused)
		else $error("store answer wrong");
	store_quiet_a: assert property (!coreStoreReq |=> !flashCmd.valid)
		else $error("flash command without request");
	load_answer_a: assert property (coreLoadReq |=> flashRead.valid != loadRefused)
		else $error("load answer wrong");
	load_quiet_a: assert property (!coreLoadReq |=> !flashRead.valid)
		else $error("flash read without request");
	write_wait_a: assert property (takeReq && hwrite |=> !hreadyout ##1 hreadyout)
		else $error("write wait state wrong");
	read_ready_a: assert property (takeReq && !hwrite |=> hreadyout && !hresp)
		else $error("read not answered at once");
	irq_cause_a: assert property (irqInhibit |-> $past(coreVecInBoot) != $past(inBoot))
		else $error("interrupt inhibit without cause");
	reset_vec_a: assert property (upCnt == 3'h7 |-> resetVector ==
		(fuseBootResetPin ? bflg_pkg::APP_RESET_ADDR : BOOT_START_WORD))
		else $error("reset vector wrong");
endmodule

bind bflg_guard bflg_checker #(.BOOT_START_WORD(BOOT_START_WORD)) bflg_checker_inst (
	.mclk, .rst_n, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp,
	.coreExecAddr, .coreStoreReq, .coreLoadReq, .coreVecInBoot, .fuseBootResetPin,
	.flashCmd, .flashRead, .storeRefused, .loadRefused, .irqInhibit, .resetVector
);

// ---- testbench/bflg_core_model.sv ----
// Model of the CPU core that issues store and load requests to the guard.
// Assumes its tasks are called from the bench, which shares mclk.
`timescale 1ns/1ps
module bflg_core_model (
	input wire logic mclk,
	output logic [14:0] coreExecAddr,
	output logic coreStoreReq,
	output logic coreLoadReq,
	output logic coreVecInBoot
);
	// The core starts in application code with vectors in the application.
	initial begin
		coreExecAddr = 15'h0000;
		coreStoreReq = 1'h0;
		coreLoadReq = 1'h0;
		coreVecInBoot = 1'h0;
	end
	// Pulses one request for one cycle, then returns once the answer has settled.
	task automatic issue(input logic isStore, input logic [14:0] exec);
		@(posedge mclk);
		coreExecAddr <= exec;
		coreStoreReq <= isStore;
		coreLoadReq <= !isStore;
		@(posedge mclk);
		coreStoreReq <= 1'h0;
		coreLoadReq <= 1'h0;
		@(negedge mclk);
	endtask
	// Moves execution and the vector table, then lets the inhibit settle.
	task automatic place(input logic [14:0] exec, input logic vec);
		@(posedge mclk);
		coreExecAddr <= exec;
		coreVecInBoot <= vec;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the flash guard: AHB register access and core requests.
// Assumes the checker binds itself and the core model drives the core-side inputs.
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] PTR = bflg_pkg::OFS_POINTER;
	localparam logic [7:0] CTL = bflg_pkg::OFS_CONTROL;
	localparam logic [7:0] GRD = bflg_pkg::OFS_GUARD;
	localparam logic [14:0] BT = 15'h0C10;
	localparam logic [14:0] AP = 15'h0100;
	logic mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [14:0] coreExecAddr, resetVector;
	logic coreStoreReq, coreLoadReq, coreVecInBoot, fuseBootResetPin;
	logic progChipErasePin, progGuardStrobePin, storeRefused, loadRefused, irqInhibit;
	logic [3:0] progGuardDataPin;
	bflg_pkg::bflg_flash_cmd_type flashCmd;
	bflg_pkg::bflg_flash_read_type flashRead;
	int nFail = 0;
	int totalChecks = 0;
	// The single slave's ready output is the bus ready.
	assign hready = hreadyout;
	always #20 mclk = ~mclk;
	bflg_guard bflg_guard_inst (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hrdata, .hresp, .coreExecAddr, .coreStoreReq,
		.coreLoadReq, .coreVecInBoot, .fuseBootResetPin, .progChipErasePin,
		.progGuardStrobePin, .progGuardDataPin, .flashCmd, .flashRead, .storeRefused,
		.loadRefused, .irqInhibit, .resetVector);
	bflg_core_model bflg_core_model_inst (.mclk, .coreExecAddr, .coreStoreReq,
		.coreLoadReq, .coreVecInBoot);
	// Compares a word value.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Compares a single flag.
	task automatic chkb(input string what, input logic exp, input logic got);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// One single AHB transfer; holds each phase until ready is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= bflg_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do begin
			@(posedge mclk);
		end while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge mclk);
		end while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	// Pulses a programmer pin with the given guard data held around it.
	task automatic pin(input logic erase, input logic [3:0] d);
		@(posedge mclk);
		progGuardDataPin <= d;
		repeat (4) @(posedge mclk);
		progChipErasePin <= erase;
		progGuardStrobePin <= !erase;
		repeat (6) @(posedge mclk);
		progChipErasePin <= 1'h0;
		progGuardStrobePin <= 1'h0;
		repeat (6) @(posedge mclk);
	endtask
	// Watchdog against a hung handshake.
	initial begin
		repeat (5000) @(posedge mclk);
		nFail++;
		reportAndStop();
	end
	// Main test sequence.
	initial begin
		mclk = 1'h0;
		rst_n = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = bflg_pkg::HSIZE_WORD;
		hwdata = 32'h0;
		fuseBootResetPin = 1'h1;
		progChipErasePin = 1'h0;
		progGuardStrobePin = 1'h0;
		progGuardDataPin = 4'hF;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		bus(1, PTR, 32'h1234);
		bus(0, CTL, 0);
		chk("control reset", 32'h3C, rd);
		bus(1, GRD, 0);
		bus(0, GRD, 0);
		chk("guard reset", 32'h3D, rd);
		bus(0, 8'h10, 0);
		chk("unmapped read", 0, rd);
		chk("reset vector", 0, {17'h0, resetVector});
		bus(1, CTL, 32'h3D);
		bflg_core_model_inst.issue(1, BT);
		chk("erase cmd", {14'h0, 1'h1, 2'h1, 10'h048, 5'h1A}, {14'h0, flashCmd[21:4]});
		chkb("erase refused", 0, storeRefused);
		bus(1, PTR, 0);
		bus(0, bflg_pkg::OFS_STATUS, 0);
		chk("latched word", 32'h091A, rd & 32'h7FFF);
		chk("held page", 32'h048, {22'h0, flashCmd.page});
		bus(1, PTR, 32'h1234);
		bus(1, CTL, 32'h3E);
		bflg_core_model_inst.issue(1, BT);
		chk("write cmd", {14'h0, 1'h1, 2'h2, 10'h048, 5'h1A}, {14'h0, flashCmd[21:4]});
		bus(1, CTL, 32'h3C);
		bflg_core_model_inst.issue(1, BT);
		chk("fill cmd", {14'h0, 1'h1, 2'h0, 10'h048, 5'h1A}, {14'h0, flashCmd[21:4]});
		bflg_core_model_inst.issue(1, AP);
		chkb("app store refused", 1, storeRefused);
		bus(1, PTR, 32'h1235);
		bflg_core_model_inst.issue(0, AP);
		chk("load addr", {15'h0, 1'h1, 15'h091A, 1'h1}, {15'h0, flashRead});
		bus(1, PTR, 32'hFFFF);
		bus(1, CTL, 32'h33);
		bflg_core_model_inst.issue(1, BT);
		bus(0, GRD, 0);
		chk("guard set", 32'h30, rd & 32'h3C);
		bus(1, PTR, 32'h1234);
		bus(1, CTL, 32'h3F);
		bflg_core_model_inst.issue(1, BT);
		chkb("guard op ignores pointer", 0, storeRefused);
		chk("cmd guard", 32'hC, {28'h0, flashCmd.guard});
		bus(0, GRD, 0);
		chk("guard kept", 32'h30, rd & 32'h3C);
		bus(1, PTR, 32'h1234);
		bus(1, CTL, 32'h3E);
		bflg_core_model_inst.issue(1, BT);
		chkb("app write guard", 1, storeRefused);
		bflg_core_model_inst.issue(0, BT);
		chkb("app read guard", 1, loadRefused);
		bus(0, bflg_pkg::OFS_STATUS, 0);
		chk("status flags", 32'h6, rd >> 16);
		bus(1, PTR, 32'h2000);
		bflg_core_model_inst.issue(1, BT);
		chkb("boot open", 0, storeRefused);
		bflg_core_model_inst.place(AP, 1);
		chkb("app irq inhibit", 1, irqInhibit);
		bflg_core_model_inst.place(BT, 1);
		chkb("boot irq free", 0, irqInhibit);
		pin(1, 4'hF);
		bus(0, GRD, 0);
		chk("chip erase", 32'h3C, rd & 32'h3C);
		pin(0, 4'h3);
		bus(0, GRD, 0);
		chk("pin guard", 32'h0C, rd & 32'h3C);
		bflg_core_model_inst.issue(1, BT);
		chkb("boot write guard", 1, storeRefused);
		bflg_core_model_inst.issue(0, AP);
		chkb("boot read guard", 1, loadRefused);
		bflg_core_model_inst.place(BT, 0);
		chkb("boot irq inhibit", 1, irqInhibit);
		@(posedge mclk);
		rst_n <= 1'h0;
		fuseBootResetPin <= 1'h0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (8) @(posedge mclk);
		chk("boot reset vector", 32'h0C00, {17'h0, resetVector});
		reportAndStop();
	end
endmodule
